// *** pkg/fbep_map.svh ***
// Address map, protection encodings and geometry constants for the flash block erase protect unit.
// Overview of operation
// - The array is 16 KB made of 1-KB blocks, and any one block can be erased without touching the others.
// - A finished erase leaves every bit of the erased block at one.
// - Protection is set per 2-KB region, which is two adjacent erase blocks, and each region has its own setting.
// - Each region can be marked read-only or execute-only.
// - Erase and program requests into a read-only region are refused so its contents never change.
// - Erase and program requests into an execute-only region are refused.
// - An execute-only region answers instruction fetches only; data reads and debugger reads are denied.
`ifndef FBEP_MAP_SVH
`define FBEP_MAP_SVH

// ==========================================================================
// Geometry
// ==========================================================================
`define FBEP_ARRAY_BYTES    16384
`define FBEP_BLOCK_BYTES    1024
`define FBEP_REGION_BYTES   2048
`define FBEP_WORD_BYTES     4
`define FBEP_ERASED_WORD    32'hFFFFFFFF

// ==========================================================================
// Protection attribute field positions
// ==========================================================================
`define FBEP_ATTR_RO_BIT    0
`define FBEP_ATTR_XO_BIT    1

`endif

// *** pkg/fbep_pkg.sv ***
// Types shared by the flash block erase protect unit.
package fbep_pkg;

    typedef enum logic [2:0]
    {
        FBEP_OP_FETCH = 3'h0,
        FBEP_OP_DREAD = 3'h1,
        FBEP_OP_DBG   = 3'h2,
        FBEP_OP_PROG  = 3'h3,
        FBEP_OP_ERASE = 3'h4
    } fbep_op_t;

    typedef enum logic [2:0]
    {
        FBEP_ST_IDLE  = 3'b001,
        FBEP_ST_ERASE = 3'b010,
        FBEP_ST_DONE  = 3'b100
    } fbep_state_t;

endpackage : fbep_pkg

// *** hw/fbep_guard.sv ***
// Protection decision for one request against the per-region attribute vector.
`timescale 1ns/1ps
`default_nettype none
`include "fbep_map.svh"

module fbep_guard
    import fbep_pkg::*;
#(
    parameter int REGIONS = 8,
    parameter int RW      = 3
)
(
    input  wire logic [RW-1:0]      region,
    input  wire fbep_op_t           op,
    input  wire logic [REGIONS-1:0] ro_mask,
    input  wire logic [REGIONS-1:0] xo_mask,
    output logic                    deny
);

    logic ro;
    logic xo;

    always_comb
    begin
        ro   = ro_mask[region];
        xo   = xo_mask[region];
        deny = 1'b0;
        unique case (op)
            FBEP_OP_PROG, FBEP_OP_ERASE: deny = ro | xo;
            FBEP_OP_DREAD, FBEP_OP_DBG:  deny = xo;
            FBEP_OP_FETCH:               deny = 1'b0;
            default:                     deny = 1'b1;
        endcase
    end

endmodule : fbep_guard
`default_nettype wire

// *** hw/fbep_top.sv ***
// Flash array with block erase and per-region read-only and execute-only protection.
`timescale 1ns/1ps
`default_nettype none
`include "fbep_map.svh"

module fbep_top
    import fbep_pkg::*;
#(
    parameter int ARRAY_BYTES  = `FBEP_ARRAY_BYTES,
    parameter int BLOCK_BYTES  = `FBEP_BLOCK_BYTES,
    parameter int REGION_BYTES = `FBEP_REGION_BYTES,
    localparam int WORDS       = ARRAY_BYTES / `FBEP_WORD_BYTES,
    localparam int BWORDS      = BLOCK_BYTES / `FBEP_WORD_BYTES,
    localparam int REGIONS     = ARRAY_BYTES / REGION_BYTES,
    localparam int AW          = $clog2(WORDS),
    localparam int BW          = $clog2(BWORDS),
    localparam int RW          = $clog2(REGIONS)
)
(
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               clock_enable,
    input  wire logic               req_valid,
    input  wire fbep_op_t           req_op,
    input  wire logic [AW-1:0]      req_word_addr,
    input  wire logic [31:0]        req_wdata,
    input  wire logic [REGIONS-1:0] read_only_mask,
    input  wire logic [REGIONS-1:0] exec_only_mask,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output logic                    rsp_error,
    output logic [31:0]             rsp_rdata
);

    // ==========================================================================
    // Storage
    // ==========================================================================
    // Programming can only clear bits, as in real flash; only erase returns them to one.
    // Reset does not touch the array, so stored code survives a warm restart.
    // The array is given its erased contents once, at the start of simulation.
    logic [31:0] mem [WORDS] = '{default: `FBEP_ERASED_WORD};

    fbep_state_t       state_reg;
    fbep_state_t       state_next;
    logic [AW-BW-1:0]  blk_reg;
    logic [AW-BW-1:0]  blk_next;
    logic [BW-1:0]     ptr_reg;
    logic [BW-1:0]     ptr_next;
    logic              ready_reg;
    logic              ready_next;
    logic              vld_reg;
    logic              vld_next;
    logic              err_reg;
    logic              err_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic              deny;
    logic              take;
    logic              wr_en;
    logic [AW-1:0]     wr_addr;
    logic [31:0]       wr_data;
    logic [RW-1:0]     req_region;
    logic              erase_last;

    // ==========================================================================
    // Protection check
    // ==========================================================================
    // The region is taken from the top address bits, so one region always spans two whole
    // erase blocks and an erase can never straddle two protection settings.
    function automatic logic [RW-1:0] region_of(input logic [AW-1:0] a);
        region_of = a[AW-1 -: RW];
    endfunction : region_of

    assign req_region = region_of(req_word_addr);

    // The decision is combinational, so a refusal is answered as quickly as a grant.
    fbep_guard #(
        .REGIONS (REGIONS),
        .RW      (RW)
    ) u_guard (
        .region  (req_region),
        .op      (req_op),
        .ro_mask (read_only_mask),
        .xo_mask (exec_only_mask),
        .deny    (deny)
    );

    // ==========================================================================
    // Request acceptance
    // ==========================================================================
    // Nothing is taken while an erase runs, so no master can read a half-erased block and
    // no program can race the erase pointer.
    assign take       = clock_enable & req_valid & ready_reg & (state_reg == FBEP_ST_IDLE);
    assign erase_last = (ptr_reg == BW'(BWORDS - 1));

    // ==========================================================================
    // Sequencer
    // ==========================================================================
    // The response valid is a pulse of one enabled cycle; error and data hold until the next request is taken.
    always_comb
    begin
        state_next = state_reg;
        blk_next   = blk_reg;
        ptr_next   = ptr_reg;
        ready_next = ready_reg;
        vld_next   = 1'b0;
        err_next   = err_reg;
        rdata_next = rdata_reg;
        wr_en      = 1'b0;
        wr_addr    = {blk_reg, ptr_reg};
        wr_data    = `FBEP_ERASED_WORD;
        unique case (state_reg)
            FBEP_ST_IDLE:
            begin
                ready_next = 1'b1;
                if (take)
                begin
                    vld_next   = 1'b1;
                    err_next   = deny;
                    rdata_next = 32'h00000000;
                    // A refusal writes nothing and returns zero data, so a denied read leaks nothing.
                    if (deny)
                    begin
                        vld_next = 1'b1;
                    end
                    else if (req_op == FBEP_OP_ERASE)
                    begin
                        vld_next   = 1'b0;
                        ready_next = 1'b0;
                        // The block index is latched, so the address may change once the request is taken.
                        blk_next   = req_word_addr[AW-1:BW];
                        ptr_next   = '0;
                        state_next = FBEP_ST_ERASE;
                    end
                    else if (req_op == FBEP_OP_PROG)
                    begin
                        wr_en   = 1'b1;
                        wr_addr = req_word_addr;
                        wr_data = mem[req_word_addr] & req_wdata;
                    end
                    else
                    begin
                        rdata_next = mem[req_word_addr];
                    end
                end
            end
            FBEP_ST_ERASE:
            begin
                // One word per enabled cycle; a low clock enable only stretches the erase.
                wr_en    = 1'b1;
                ptr_next = ptr_reg + BW'(1);
                if (erase_last)
                begin
                    state_next = FBEP_ST_DONE;
                end
            end
            FBEP_ST_DONE:
            begin
                // The erase is answered only after its last word is written.
                vld_next   = 1'b1;
                err_next   = 1'b0;
                ready_next = 1'b1;
                state_next = FBEP_ST_IDLE;
            end
            default:
            begin
                state_next = FBEP_ST_IDLE;
            end
        endcase
    end

    // ==========================================================================
    // State registers
    // ==========================================================================
    // Reset wins over a low clock enable, so a frozen block can still be brought to idle.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= FBEP_ST_IDLE;
            blk_reg   <= '0;
            ptr_reg   <= '0;
            ready_reg <= 1'b0;
            vld_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else if (clock_enable)
        begin
            state_reg <= state_next;
            blk_reg   <= blk_next;
            ptr_reg   <= ptr_next;
            ready_reg <= ready_next;
            vld_reg   <= vld_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================================
    // Array write port
    // ==========================================================================
    // One write port serves both program and erase; the sequencer never asks for both at once.
    always_ff @(posedge clock)
    begin
        if (clock_enable && !reset && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    // Every output is a register, so masters see settled values one cycle after the take.
    assign req_ready = ready_reg;
    assign rsp_valid = vld_reg;
    assign rsp_error = err_reg;
    assign rsp_rdata = rdata_reg;

endmodule : fbep_top
`default_nettype wire

// *** tb/fbep_monitor.sv ***
// Port checker for the flash block erase protect unit.
`timescale 1ns/1ps
`default_nettype none
module fbep_monitor
    import fbep_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clock_enable,
    input wire logic        req_valid,
    input wire fbep_op_t    req_op,
    input wire logic [11:0] req_word_addr,
    input wire logic [7:0]  read_only_mask,
    input wire logic [7:0]  exec_only_mask,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_error,
    input wire logic [31:0] rsp_rdata
);
    // ======================================================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire tk = clock_enable && req_valid && req_ready;
    wire ro = read_only_mask[req_word_addr[11:9]];
    wire xo = exec_only_mask[req_word_addr[11:9]];
    wire wr = req_op == FBEP_OP_PROG || req_op == FBEP_OP_ERASE;
    wire dr = req_op == FBEP_OP_DREAD || req_op == FBEP_OP_DBG;
    property p_er; tk && req_op == FBEP_OP_ERASE && !ro && !xo |=> !req_ready ##257 rsp_valid && !rsp_error; endproperty
    a_er: assert property (p_er) else $error("erase answer");
    property p_pr; tk && req_op == FBEP_OP_PROG && !ro && !xo |=> rsp_valid && !rsp_error; endproperty
    a_pr: assert property (p_pr) else $error("program refused");
    property p_rr; tk && dr && ro && !xo |=> rsp_valid && !rsp_error; endproperty
    a_rr: assert property (p_rr) else $error("read denied");
    property p_rw; tk && wr && ro |=> rsp_valid && rsp_error; endproperty
    a_rw: assert property (p_rw) else $error("write to locked");
    property p_xw; tk && wr && xo |=> rsp_valid && rsp_error; endproperty
    a_xw: assert property (p_xw) else $error("write to exec");
    property p_xr; tk && dr && xo |=> rsp_valid && rsp_error; endproperty
    a_xr: assert property (p_xr) else $error("data read of exec");
    property p_fe; tk && req_op == FBEP_OP_FETCH |=> rsp_valid && !rsp_error; endproperty
    a_fe: assert property (p_fe) else $error("fetch refused");
    property p_ed; rsp_valid && rsp_error |-> rsp_rdata == 32'h0; endproperty
    a_ed: assert property (p_ed) else $error("data on refusal");
    c_er: cover property (tk && req_op == FBEP_OP_ERASE);
    c_xr: cover property (tk && dr && xo);
    c_rw: cover property (tk && wr && ro);
endmodule : fbep_monitor
bind fbep_top fbep_monitor u_mon (.clock, .reset, .clock_enable, .req_valid, .req_op, .req_word_addr,
    .read_only_mask, .exec_only_mask, .req_ready, .rsp_valid, .rsp_error, .rsp_rdata);
`default_nettype wire

// *** tb/fbep_requester.sv ***
// Bus master model issuing one flash request at a time.
`timescale 1ns/1ps
`default_nettype none
module fbep_requester
    import fbep_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    output logic             req_valid,
    output fbep_op_t         req_op,
    output logic [11:0]      req_word_addr,
    output logic [31:0]      req_wdata
);
    initial
    begin
        req_valid = 1'b0;
        req_op = FBEP_OP_FETCH;
        req_word_addr = 12'h0;
        req_wdata = 32'h0;
    end
    // ======================================================================
    // Request cycle
    task automatic access(input fbep_op_t op, input logic [11:0] a, input logic [31:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge clock) #1;
        req_valid = 1'b1;
        req_op = op;
        req_word_addr = a;
        req_wdata = d;
        while (!req_ready && n < 400)
        begin
            @(posedge clock) #1;
            n++;
        end
        ok = n < 400;
        @(posedge clock) #1;
        req_valid = 1'b0;
        // Released lines show the inverse so a stale value can never pass for a fresh one.
        req_word_addr = ~a;
        req_wdata = ~d;
        n = 0;
        while (!rsp_valid && n < 300)
        begin
            @(posedge clock) #1;
            n++;
        end
        ok = ok && rsp_valid;
    endtask : access
endmodule : fbep_requester
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench for the flash block erase protect unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fbep_pkg::*;
;
    logic        clock, reset, clock_enable, req_valid, req_ready, rsp_valid, rsp_error;
    fbep_op_t    req_op;
    logic [11:0] req_word_addr;
    logic [31:0] req_wdata, rsp_rdata;
    logic [7:0]  read_only_mask, exec_only_mask;
    int          mismatches, check_count;
    fbep_top uut (.clock, .reset, .clock_enable, .req_valid, .req_op, .req_word_addr, .req_wdata,
        .read_only_mask, .exec_only_mask, .req_ready, .rsp_valid, .rsp_error, .rsp_rdata);
    fbep_requester master (.clock, .req_ready, .rsp_valid, .req_valid, .req_op, .req_word_addr, .req_wdata);
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ======================================================================
    // Checking helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic rq(input fbep_op_t op, input logic [11:0] a, input logic [31:0] d, input logic ee,
                      input logic [31:0] eq);
        logic ok;
        master.access(op, a, d, ok);
        check("handshake", {31'h0, ok}, 32'h1);
        check("error", {31'h0, rsp_error}, {31'h0, ee});
        check("rdata", rsp_rdata, eq);
        if (!ok)
            tally_and_finish();
    endtask : rq
    // ======================================================================
    // Scenarios
    task automatic t_erase;
        rq(FBEP_OP_PROG, 12'h000, 32'h0, 1'b0, 32'h0);
        rq(FBEP_OP_PROG, 12'h100, 32'h000000F0, 1'b0, 32'h0);
        rq(FBEP_OP_DREAD, 12'h100, 32'h0, 1'b0, 32'h000000F0);
        rq(FBEP_OP_ERASE, 12'h1C0, 32'h0, 1'b0, 32'h0);
        rq(FBEP_OP_DREAD, 12'h100, 32'h0, 1'b0, 32'hFFFFFFFF);
        rq(FBEP_OP_DBG, 12'h1FF, 32'h0, 1'b0, 32'hFFFFFFFF);
        rq(FBEP_OP_DREAD, 12'h000, 32'h0, 1'b0, 32'h0);
    endtask : t_erase
    task automatic t_ro;
        rq(FBEP_OP_PROG, 12'h200, 32'h0F0F0F0F, 1'b0, 32'h0);
        read_only_mask = 8'h02;
        rq(FBEP_OP_PROG, 12'h200, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_ERASE, 12'h3FF, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_PROG, 12'h1FF, 32'h0, 1'b0, 32'h0);
        rq(FBEP_OP_DREAD, 12'h200, 32'h0, 1'b0, 32'h0F0F0F0F);
        rq(FBEP_OP_DBG, 12'h200, 32'h0, 1'b0, 32'h0F0F0F0F);
    endtask : t_ro
    task automatic t_xo;
        rq(FBEP_OP_PROG, 12'h400, 32'h12345678, 1'b0, 32'h0);
        exec_only_mask = 8'h04;
        rq(FBEP_OP_FETCH, 12'h400, 32'h0, 1'b0, 32'h12345678);
        rq(FBEP_OP_DREAD, 12'h400, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_DBG, 12'h5FF, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_PROG, 12'h400, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_ERASE, 12'h400, 32'h0, 1'b1, 32'h0);
        rq(fbep_op_t'(3'h5), 12'h400, 32'h0, 1'b1, 32'h0);
        rq(FBEP_OP_FETCH, 12'h400, 32'h0, 1'b0, 32'h12345678);
    endtask : t_xo
    task automatic t_freeze;
        clock_enable = 1'b0;
        repeat (3) @(posedge clock) #1;
        check("frozen valid", {31'h0, rsp_valid}, 32'h1);
        check("frozen rdata", rsp_rdata, 32'h12345678);
        clock_enable = 1'b1;
        @(posedge clock) #1;
        check("released valid", {31'h0, rsp_valid}, 32'h0);
    endtask : t_freeze
    initial
    begin
        mismatches = 0;
        check_count = 0;
        reset = 1'b1;
        clock_enable = 1'b1;
        read_only_mask = 8'h00;
        exec_only_mask = 8'h00;
        repeat (4) @(posedge clock);
        #1 reset = 1'b0;
        t_erase();
        t_ro();
        t_xo();
        t_freeze();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
